// ### hw/drss_sequencer.sv
`timescale 1ns/1ns
`default_nettype none
`include "drss_regs.svh"
// Behaviour
// - power-up terminal check only when run source is terminals; sampled at power-up
// - guard 0: active terminal at power-up ignored until released and asserted again
// - guard 1: terminal active at power-up starts run after initialization
// - below floor: 0 run at floor, 1 stop, 2 sleep
// - entering sleep coasts the motor to stop
// - wake only after set frequency stays above floor for wake delay
// - wake delay applies only under sleep code
// - restart on repower 1 runs after repower wait if start conditions hold
// - repower wait 0.0 to 6553.5 s default 1.0 s, used only when enabled
// - start delay withholds output after run command or wake
// - open-loop zero hz: 0 no voltage, 1 voltage, 2 stop dc current
// - stop speed reached only after stop detection time
// - stop speed source: 0 set speed, 1 measured speed
module drss_sequencer #(
   parameter int unsigned TICK_CYC = `DRSS_TICK_CYC,
   parameter int unsigned FW       = 16
) (
   input  wire logic                 i_clock,
   input  wire logic                 i_srst,
   input  wire drss_pkg::drss_bus_s  i_bus,
   input  wire logic                 i_run_term,
   input  wire logic                 i_repower,
   input  wire logic                 i_open_loop,
   input  wire logic [FW-1:0]        i_set_freq,
   input  wire logic [FW-1:0]        i_floor_freq,
   input  wire logic [FW-1:0]        i_meas_freq,
   input  wire logic [FW-1:0]        i_stop_freq,
   output logic [15:0]               o_rdata,
   output drss_pkg::drss_drive_s     o_drive,
   output logic                      o_stop_reached,
   output logic                      o_sleeping
);
   import drss_pkg::*;

   // ----------------------------------------
   // register file
   // ----------------------------------------
   logic [7:0]  ctrl_q;
   logic [15:0] wake_q;
   logic [15:0] repwr_q;
   logic [15:0] start_q;
   logic [15:0] stopt_q;
   drss_state_e state_q;

   always_ff @(posedge i_clock) begin
      if (i_srst) begin
         ctrl_q  <= `DRSS_CTRL_RST;
         wake_q  <= `DRSS_WAKE_RST;
         repwr_q <= `DRSS_REPWR_RST;
         start_q <= `DRSS_START_RST;
         stopt_q <= `DRSS_STOPT_RST;
      end else if (i_bus.wr) begin
         case (i_bus.addr)
            `DRSS_ADDR_CTRL:  ctrl_q  <= i_bus.wdata[7:0];
            `DRSS_ADDR_WAKE:  wake_q  <= i_bus.wdata;
            `DRSS_ADDR_REPWR: repwr_q <= i_bus.wdata;
            `DRSS_ADDR_START: start_q <= i_bus.wdata;
            `DRSS_ADDR_STOPT: stopt_q <= i_bus.wdata;
            default: ;
         endcase
      end
   end

   // unmapped addresses read zero
   always_ff @(posedge i_clock) begin
      if (i_srst) begin
         o_rdata <= 16'h0000;
      end else if (i_bus.rd) begin
         case (i_bus.addr)
            `DRSS_ADDR_CTRL:   o_rdata <= {8'h00, ctrl_q};
            `DRSS_ADDR_WAKE:   o_rdata <= wake_q;
            `DRSS_ADDR_REPWR:  o_rdata <= repwr_q;
            `DRSS_ADDR_START:  o_rdata <= start_q;
            `DRSS_ADDR_STOPT:  o_rdata <= stopt_q;
            `DRSS_ADDR_STATUS: o_rdata <= {8'h00, o_stop_reached, o_sleeping, state_q};
            default:           o_rdata <= 16'h0000;
         endcase
      end else begin
         o_rdata <= 16'h0000;
      end
   end

   wire logic       guard   = ctrl_q[`DRSS_CTRL_GUARD];
   wire logic [1:0] floor_a = ctrl_q[`DRSS_CTRL_FLOOR_HI:`DRSS_CTRL_FLOOR_LO];
   wire logic       restart = ctrl_q[`DRSS_CTRL_RESTART];
   wire logic [1:0] zsel    = ctrl_q[`DRSS_CTRL_ZSEL_HI:`DRSS_CTRL_ZSEL_LO];
   wire logic       ssrc    = ctrl_q[`DRSS_CTRL_SSRC];
   wire logic       termsrc = ctrl_q[`DRSS_CTRL_TERMSRC];

   // ----------------------------------------
   // 0.01 s time base
   // ----------------------------------------
   // one shared prescaler keeps the long timers at 0.01 s resolution
   logic [31:0] pre_q;
   logic        tick_q;
   always_ff @(posedge i_clock) begin
      if (i_srst || pre_q == 32'(TICK_CYC - 1)) begin
         pre_q <= 32'h00000000;
      end else begin
         pre_q <= pre_q + 32'h00000001;
      end
   end
   always_ff @(posedge i_clock) begin
      if (i_srst) begin
         tick_q <= 1'b0;
      end else begin
         tick_q <= (pre_q == 32'(TICK_CYC - 1));
      end
   end

   // ----------------------------------------
   // sequencer
   // ----------------------------------------
   logic [19:0] tmr_q;
   logic        term_d1_q;
   logic        pwr_active_q;
   logic        repwr_pend_q;
   wire logic   above    = i_set_freq > i_floor_freq;
   wire logic   run_cmd  = termsrc ? i_run_term : 1'b0;
   wire logic   term_rise = i_run_term && !term_d1_q;
   wire logic [19:0] wake_lim  = {4'h0, wake_q} * 20'h0000A;
   wire logic [19:0] start_lim = {4'h0, start_q} * 20'h0000A;
   wire logic [19:0] repwr_lim = {4'h0, repwr_q} * 20'h0000A;

   always_ff @(posedge i_clock) begin
      if (i_srst) begin
         term_d1_q <= 1'b0;
      end else begin
         term_d1_q <= i_run_term;
      end
   end

   // power-up terminal capture, taken after reset release
   always_ff @(posedge i_clock) begin
      if (i_srst) begin
         pwr_active_q <= 1'b0;
         repwr_pend_q <= 1'b0;
      end else if (state_q == DRSS_INIT) begin
         pwr_active_q <= termsrc && i_run_term;
         repwr_pend_q <= i_repower && restart;
      end else begin
         // a released terminal ends the power-up hold; a started run uses up the restart
         if (!i_run_term) begin
            pwr_active_q <= 1'b0;
         end
         if (state_q == DRSS_DELAY) begin
            repwr_pend_q <= 1'b0;
         end
      end
   end

   always_ff @(posedge i_clock) begin
      if (i_srst) begin
         state_q <= DRSS_INIT;
         tmr_q   <= 20'h00000;
      end else begin
         case (state_q)
            DRSS_INIT: begin
               tmr_q <= 20'h00000;
               // settings are written after reset, so hold one tick before acting on them
               if (!tick_q) begin
                  state_q <= DRSS_INIT;
               end else if (termsrc && i_run_term && !guard) begin
                  state_q <= DRSS_GUARD;
               end else begin
                  state_q <= DRSS_IDLE;
               end
            end
            DRSS_GUARD: begin
               if (!i_run_term) begin
                  state_q <= DRSS_IDLE;
               end
            end
            DRSS_IDLE: begin
               if (repwr_pend_q && restart && run_cmd) begin
                  // wait repower time before the start delay
                  if (tick_q) tmr_q <= tmr_q + 20'h00001;
                  if (tmr_q >= repwr_lim) begin
                     state_q <= DRSS_DELAY;
                     tmr_q   <= 20'h00000;
                  end
               end else if ((pwr_active_q && guard && run_cmd) ||
                            (run_cmd && (term_rise || !pwr_active_q))) begin
                  if (!(floor_a == 2'h1 && !above)) begin
                     state_q <= DRSS_DELAY;
                     tmr_q   <= 20'h00000;
                  end
               end
            end
            DRSS_DELAY: begin
               if (!run_cmd) begin
                  state_q <= DRSS_IDLE;
               end else if (tmr_q >= start_lim) begin
                  state_q <= DRSS_RUN;
                  tmr_q   <= 20'h00000;
               end else if (tick_q) begin
                  tmr_q <= tmr_q + 20'h00001;
               end
            end
            DRSS_RUN: begin
               if (!run_cmd || (floor_a == 2'h1 && !above)) begin
                  state_q <= DRSS_IDLE;
               end else if (floor_a == 2'h2 && !above) begin
                  state_q <= DRSS_SLEEP;
                  tmr_q   <= 20'h00000;
               end
            end
            DRSS_SLEEP: begin
               if (!run_cmd || floor_a != 2'h2) begin
                  state_q <= DRSS_IDLE;
               end else if (!above) begin
                  tmr_q <= 20'h00000;
               end else if (tmr_q >= wake_lim) begin
                  state_q <= DRSS_DELAY;
                  tmr_q   <= 20'h00000;
               end else if (tick_q) begin
                  tmr_q <= tmr_q + 20'h00001;
               end
            end
            default: state_q <= DRSS_INIT;
         endcase
      end
   end

   // ----------------------------------------
   // outputs
   // ----------------------------------------
   // zero-hz choice only in open loop at zero output; run at floor handled upstream
   wire logic at_zero = (i_set_freq == '0) || (!above && floor_a == 2'h0 && i_floor_freq == '0);
   always_ff @(posedge i_clock) begin
      if (i_srst) begin
         o_drive    <= '0;
         o_sleeping <= 1'b0;
      end else begin
         o_drive.run       <= state_q == DRSS_RUN;
         o_drive.coast     <= state_q == DRSS_SLEEP;
         o_drive.zero_volt <= state_q == DRSS_RUN && i_open_loop && at_zero
                              && zsel == 2'h1;
         o_drive.zero_dc   <= state_q == DRSS_RUN && i_open_loop && at_zero
                              && zsel == 2'h2;
         o_sleeping        <= state_q == DRSS_SLEEP;
      end
   end

   // stop speed detection with hold time
   logic [15:0] stop_tmr_q;
   wire logic [FW-1:0] cmp_freq = ssrc ? i_meas_freq : i_set_freq;
   always_ff @(posedge i_clock) begin
      if (i_srst || cmp_freq > i_stop_freq) begin
         stop_tmr_q <= 16'h0000;
      end else if (tick_q && stop_tmr_q < stopt_q) begin
         stop_tmr_q <= stop_tmr_q + 16'h0001;
      end
   end
   always_ff @(posedge i_clock) begin
      if (i_srst) begin
         o_stop_reached <= 1'b0;
      end else begin
         o_stop_reached <= cmp_freq <= i_stop_freq && stop_tmr_q >= stopt_q;
      end
   end

   // ----------------------------------------
   // checks
   // ----------------------------------------
   property p_guard_hold;
      @(posedge i_clock) disable iff (i_srst)
      state_q == DRSS_GUARD && i_run_term |=> state_q == DRSS_GUARD;
   endproperty
   a_guard_hold: assert property (p_guard_hold) else $error("guard left early");

   property p_sleep_coast;
      @(posedge i_clock) disable iff (i_srst)
      state_q == DRSS_SLEEP |=> o_drive.coast && !o_drive.run;
   endproperty
   a_sleep_coast: assert property (p_sleep_coast) else $error("sleep not coasting");

   property p_wake_low;
      @(posedge i_clock) disable iff (i_srst)
      state_q == DRSS_SLEEP && !above && run_cmd && floor_a == 2'h2 |=> tmr_q == 20'h00000;
   endproperty
   a_wake_low: assert property (p_wake_low) else $error("wake timer kept");

   property p_stop_floor;
      @(posedge i_clock) disable iff (i_srst)
      state_q == DRSS_RUN && floor_a == 2'h1 && !above |=> state_q == DRSS_IDLE;
   endproperty
   a_stop_floor: assert property (p_stop_floor) else $error("no stop below floor");

   property p_delay_out;
      @(posedge i_clock) disable iff (i_srst)
      state_q == DRSS_DELAY |=> !o_drive.run;
   endproperty
   a_delay_out: assert property (p_delay_out) else $error("output during delay");

   property p_stop_time;
      @(posedge i_clock) disable iff (i_srst)
      o_stop_reached |-> $past(stop_tmr_q) >= $past(stopt_q);
   endproperty
   a_stop_time: assert property (p_stop_time) else $error("stop too soon");

   property p_zero_sel;
      @(posedge i_clock) disable iff (i_srst)
      zsel == 2'h0 |=> !(o_drive.zero_volt || o_drive.zero_dc);
   endproperty
   a_zero_sel: assert property (p_zero_sel) else $error("zero hz output wrong");

   property p_sleep_code;
      @(posedge i_clock) disable iff (i_srst)
      state_q == DRSS_SLEEP && floor_a != 2'h2 |=> state_q == DRSS_IDLE;
   endproperty
   a_sleep_code: assert property (p_sleep_code) else $error("sleep under other code");

   // power-up and restart sequencing
   sequence s_guard_exit;
      state_q == DRSS_INIT && tick_q && termsrc && i_run_term && guard;
   endsequence
   sequence s_guard_go;
      state_q == DRSS_IDLE && run_cmd && guard && !repwr_pend_q
      && !(floor_a == 2'h1 && !above);
   endsequence
   property p_guard_start;
      @(posedge i_clock) disable iff (i_srst)
      s_guard_exit ##1 s_guard_go |=> state_q == DRSS_DELAY;
   endproperty
   a_guard_start: assert property (p_guard_start) else $error("no start after init");

   sequence s_repwr_count;
      state_q == DRSS_IDLE && repwr_pend_q && restart && run_cmd && tmr_q < repwr_lim;
   endsequence
   property p_repwr_wait;
      @(posedge i_clock) disable iff (i_srst)
      s_repwr_count |=> state_q != DRSS_DELAY;
   endproperty
   a_repwr_wait: assert property (p_repwr_wait) else $error("restart before wait");
endmodule
`default_nettype wire

// ### shared/drss_pkg.sv
`default_nettype none
package drss_pkg;
   typedef enum logic [5:0] {
      DRSS_INIT   = 6'h01,
      DRSS_GUARD  = 6'h02,
      DRSS_IDLE   = 6'h04,
      DRSS_DELAY  = 6'h08,
      DRSS_RUN    = 6'h10,
      DRSS_SLEEP  = 6'h20
   } drss_state_e;
   typedef struct packed {
      logic [3:0]  addr;
      logic [15:0] wdata;
      logic        wr;
      logic        rd;
   } drss_bus_s;
   typedef struct packed {
      logic run;
      logic coast;
      logic zero_volt;
      logic zero_dc;
   } drss_drive_s;
endpackage
`default_nettype wire

// ### shared/drss_regs.svh
`ifndef DRSS_REGS_SVH
`define DRSS_REGS_SVH
// ----------------------------------------
// register offsets
// ----------------------------------------
`define DRSS_ADDR_CTRL      4'h0
`define DRSS_ADDR_WAKE      4'h1
`define DRSS_ADDR_REPWR     4'h2
`define DRSS_ADDR_START     4'h3
`define DRSS_ADDR_STOPT     4'h4
`define DRSS_ADDR_STATUS    4'h5
// ----------------------------------------
// control field positions
// ----------------------------------------
`define DRSS_CTRL_GUARD     0
`define DRSS_CTRL_FLOOR_LO  1
`define DRSS_CTRL_FLOOR_HI  2
`define DRSS_CTRL_RESTART   3
`define DRSS_CTRL_ZSEL_LO   4
`define DRSS_CTRL_ZSEL_HI   5
`define DRSS_CTRL_SSRC      6
`define DRSS_CTRL_TERMSRC   7
// ----------------------------------------
// reset values, times in 0.1 s (stop time in 0.01 s)
// ----------------------------------------
`define DRSS_CTRL_RST       8'h80
`define DRSS_WAKE_RST       16'h0000
`define DRSS_REPWR_RST      16'h000A
`define DRSS_START_RST      16'h0000
`define DRSS_STOPT_RST      16'h0032
// ----------------------------------------
// timing: clock 250 MHz, 0.01 s tick
// ----------------------------------------
`define DRSS_CLK_HZ         250000000
`define DRSS_TICK_S_DIV     100
`define DRSS_TICK_CYC       (`DRSS_CLK_HZ / `DRSS_TICK_S_DIV)
`endif

// ### verif/drss_sequencer_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
`include "drss_regs.svh"
module drss_sequencer_tb_top;
   import drss_pkg::*;
   // ----------------------------------------
   // stimulus and observed signals
   // ----------------------------------------
   logic        i_clock   = 1'b0;
   logic        i_srst    = 1'b1;
   drss_bus_s   bus       = '0;
   logic        run_req   = 1'b1;
   logic [15:0] freq_req  = 16'h00C8;
   logic        open_loop = 1'b0;
   logic        repower   = 1'b0;
   logic [15:0] floor_f   = 16'h0064;
   logic [15:0] meas_f    = 16'h0000;
   logic [15:0] stop_f    = 16'h000A;
   logic        run_term;
   logic [15:0] set_freq;
   logic [15:0] rdata;
   drss_drive_s drive;
   logic        stop_reached;
   logic        sleeping;
   logic [15:0] rd_v;
   int          error_cnt = 0;
   int          samples_checked = 0;
   int          cycles = 0;
   logic [3:0]  ra [6] = '{`DRSS_ADDR_CTRL, `DRSS_ADDR_WAKE, `DRSS_ADDR_REPWR,
                           `DRSS_ADDR_START, `DRSS_ADDR_STOPT, 4'h6};
   logic [15:0] rv [6] = '{16'h0080, `DRSS_WAKE_RST, `DRSS_REPWR_RST,
                           `DRSS_START_RST, `DRSS_STOPT_RST, 16'h0000};
   always #2 i_clock = ~i_clock;
   drss_term_model u_drss_term_model (
      .i_clock    (i_clock),
      .i_run_req  (run_req),
      .i_freq_req (freq_req),
      .o_run_term (run_term),
      .o_set_freq (set_freq)
   );
   // short tick so 0.1 s is 40 cycles
   drss_sequencer #(.TICK_CYC(4), .FW(16)) u_drss_sequencer (
      .i_clock        (i_clock),
      .i_srst         (i_srst),
      .i_bus          (bus),
      .i_run_term     (run_term),
      .i_repower      (repower),
      .i_open_loop    (open_loop),
      .i_set_freq     (set_freq),
      .i_floor_freq   (floor_f),
      .i_meas_freq    (meas_f),
      .i_stop_freq    (stop_f),
      .o_rdata        (rdata),
      .o_drive        (drive),
      .o_stop_reached (stop_reached),
      .o_sleeping     (sleeping)
   );
   // ----------------------------------------
   // helpers
   // ----------------------------------------
   task automatic results();
      $display("checks %0d mismatches %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         error_cnt++;
         $display("unexpected %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
      @(posedge i_clock);
      bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge i_clock);
      bus.wr <= 1'b0;
   endtask
   task automatic rd_reg(input logic [3:0] a, output logic [15:0] d);
      @(posedge i_clock);
      bus <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
      @(posedge i_clock);
      bus.rd <= 1'b0;
      #1 d = rdata;
   endtask
   function automatic logic sig(input int k);
      case (k)
         0: return drive.run;
         1: return sleeping;
         default: return stop_reached;
      endcase
   endfunction
   // bounded wait; the observed delay must fall in lo..hi cycles
   task automatic wait_sig(input int k, input logic v, input int lo, input int hi,
                           input string nm);
      int n;
      n = 0;
      while (sig(k) !== v && n <= hi) begin
         @(posedge i_clock);
         #1 n++;
      end
      check(nm, {15'h0000, (n >= lo && n <= hi)}, 16'h0001);
   endtask
   always @(posedge i_clock) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         error_cnt++;
         results();
      end
   end
   // ----------------------------------------
   // tests
   // ----------------------------------------
   initial begin
      repeat (16) @(posedge i_clock);
      i_srst <= 1'b0;
      for (int i = 0; i < 6; i++) begin
         rd_reg(ra[i], rd_v);
         check("reset_value", rd_v, rv[i]);
      end
      $display("test reset_values done");
      rd_reg(`DRSS_ADDR_STATUS, rd_v);
      check("guard_state", rd_v, 16'h0002);
      repeat (50) @(posedge i_clock);
      #1 check("guard_hold", {15'h0000, drive.run}, 16'h0000);
      @(posedge i_clock);
      run_req <= 1'b0;
      repeat (3) @(posedge i_clock);
      run_req <= 1'b1;
      wait_sig(0, 1'b1, 1, 12, "guard_rearm");
      $display("test power_up_guard done");
      @(posedge i_clock);
      run_req <= 1'b0;
      wait_sig(0, 1'b0, 1, 12, "run_drop");
      wr_reg(`DRSS_ADDR_START, 16'h0001);
      run_req <= 1'b1;
      wait_sig(0, 1'b1, 34, 52, "start_delay");
      wr_reg(`DRSS_ADDR_START, 16'h0000);
      $display("test start_delay done");
      wr_reg(`DRSS_ADDR_CTRL, 16'h0082);
      freq_req <= 16'h0032;
      wait_sig(0, 1'b0, 1, 12, "floor_stop");
      @(posedge i_clock);
      freq_req <= 16'h00C8;
      wait_sig(0, 1'b1, 1, 12, "floor_resume");
      wr_reg(`DRSS_ADDR_CTRL, 16'h0084);
      wr_reg(`DRSS_ADDR_WAKE, 16'h0001);
      freq_req <= 16'h0032;
      wait_sig(1, 1'b1, 1, 12, "sleep_enter");
      check("sleep_coast", {14'h0000, drive.coast, drive.run}, 16'h0002);
      @(posedge i_clock);
      freq_req <= 16'h00C8;
      repeat (20) @(posedge i_clock);
      freq_req <= 16'h0032;
      repeat (2) @(posedge i_clock);
      freq_req <= 16'h00C8;
      wait_sig(0, 1'b1, 34, 64, "wake_run");
      $display("test floor_sleep done");
      wr_reg(`DRSS_ADDR_CTRL, 16'h0080);
      freq_req <= 16'h0032;
      repeat (60) @(posedge i_clock);
      #1 check("floor_run", {15'h0000, drive.run}, 16'h0001);
      @(posedge i_clock);
      freq_req <= 16'h00C8;
      $display("test floor_run done");
      wr_reg(`DRSS_ADDR_STOPT, 16'h0002);
      floor_f <= 16'h0000;
      freq_req <= 16'h0000;
      wait_sig(2, 1'b1, 6, 16, "stop_time");
      wr_reg(`DRSS_ADDR_CTRL, 16'h00C0);
      meas_f <= 16'h01F4;
      wait_sig(2, 1'b0, 1, 8, "stop_meas_high");
      @(posedge i_clock);
      meas_f <= 16'h0000;
      wait_sig(2, 1'b1, 6, 16, "stop_meas_low");
      $display("test stop_speed done");
      @(posedge i_clock);
      open_loop <= 1'b1;
      for (int z = 0; z < 3; z++) begin
         wr_reg(`DRSS_ADDR_CTRL, 16'h0080 | 16'(z << 4));
         repeat (4) @(posedge i_clock);
         #1 check("zero_hz", {14'h0000, drive.zero_volt, drive.zero_dc},
                  {14'h0000, z == 1, z == 2});
      end
      $display("test zero_hz done");
      // mid-run power cycles: guard 1 starts at once, enabled restart waits the repower time
      for (int p = 0; p < 2; p++) begin
         @(posedge i_clock);
         i_srst  <= 1'b1;
         repower <= 1'b1;
         repeat (4) @(posedge i_clock);
         i_srst <= 1'b0;
         wr_reg(`DRSS_ADDR_CTRL, p == 0 ? 16'h0081 : 16'h0089);
         wr_reg(`DRSS_ADDR_REPWR, 16'h0001);
         wait_sig(0, 1'b1, p == 0 ? 2 : 34, p == 0 ? 12 : 56, "repower_start");
      end
      $display("test power_cycle done");
      results();
   end
endmodule
`default_nettype wire

// ### verif/drss_term_model.sv
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------
// run terminal and frequency reference
// ----------------------------------------
// registered so a changed request reaches the block one edge later, as a real terminal would
module drss_term_model (
   input  wire logic        i_clock,
   input  wire logic        i_run_req,
   input  wire logic [15:0] i_freq_req,
   output var  logic        o_run_term = 1'b0,
   output var  logic [15:0] o_set_freq = 16'h0000
);
   always_ff @(posedge i_clock) begin
      o_run_term <= i_run_req;
      o_set_freq <= i_freq_req;
   end
endmodule
`default_nettype wire
